// ==== common/asr_pkg.sv ====
// shared constants and types for the slave serial readout port
package asr_pkg;

	// ----------------------------------------------------------------
	// word and counter sizes
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] BITS_PER_WORD = 5'h10;
	localparam logic [4:0] LAST_OWN_BIT = 5'h0F;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// conversion phase length of the stand-in conversion timer
	localparam int CONV_TIME_NS = 1500;
	// least time, so round up
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
	localparam logic [7:0] CONV_CNT_RST = 8'h00;
	// highest host shift clock rate in read-after-conversion mode
	localparam int SCLK_MAX_MHZ = 40;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ASR_IDLE = 2'b00,
		ASR_CONV = 2'b01,
		ASR_STORE = 2'b11
	} asr_conv_e;

	// pins that enter the system clock domain through a synchroniser
	typedef struct packed
	{
		logic cs_n;
		logic rd_n;
		logic cnv_n;
		logic pd;
	} asr_pins_s;

	localparam int PIN_W = $bits(asr_pins_s);
	localparam asr_pins_s PINS_RST = 4'hF;

endpackage

// ==== logic/asr_sync2.sv ====
// two flip-flop level synchroniser
`timescale 1ns/100ps

module asr_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// level from another domain
	input wire logic [W-1:0] async_in,
	// level in this domain
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule // asr_sync2

// ==== logic/asr_serial_port.sv ====
// slave serial readout port with conversion timer and daisy chain
`timescale 1ns/100ps

// Overview of operation
// RQ1 - clock source select high enables external clock
// RQ2 - chip select gates clock; output needs both
// RQ3 - works with continuous or either-idle clock
// RQ4 - host keeps clock quiet late in conversion
// RQ5 - after busy falls, new result MSB first
// RQ6 - each bit held across both clock edges
// RQ7 - shift clock up to 40 MHz accepted
// RQ8 - chain input follows own 16 bits
// RQ9 - chain sampled on edge opposite shifting
// RQ10 - during conversion, previous result shifted out
// RQ11 - unfinished read at conversion end pulses overrun
// RQ12 - chain input tied fixed during-conversion reads
// RQ13 - host uses fast clock for during reads
// RQ14 - read begun after conversion may overlap next
// RQ15 - host may trigger read on busy fall
// RQ16 - host SPI idle-low, phase one works
// RQ17 - started conversion always completes, never aborts
// RQ18 - interface select high enables serial port
// RQ19 - outputs released when chip select or read high
// RQ20 - MSB shown before first edge, then advance
module asr_serial_port
(
	// system clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// host shift clock (link domain)
	input wire logic sclk_in,
	// host control pins
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic convert_start_n_in,
	input wire logic power_down_in,
	// configuration straps
	input wire logic clock_source_select_in,
	input wire logic interface_select_in,
	// daisy chain input from the upstream converter
	input wire logic chain_data_in,
	// serial output pin
	output logic serial_data_out,
	output logic serial_data_oe_out,
	// conversion engine side
	input wire logic [asr_pkg::DATA_W-1:0] conv_result_in,
	output logic conv_start_out,
	output logic busy_out,
	output logic read_overrun_flag_out
);

	import asr_pkg::*;

	localparam int CONV_WAIT = CONV_CYCLES + 2;

	// ----------------------------------------------------------------
	// port enable and pin synchronisers
	// ----------------------------------------------------------------

	asr_pins_s pins_raw;
	asr_pins_s pins_s;
	logic port_en;
	logic frame_rst_n;
	logic done_s;

	// serial slave port only with external clock and serial select
	assign port_en = clock_source_select_in & interface_select_in; // RQ1 RQ18
	// link logic held cleared while chip select is high
	assign frame_rst_n = rst_n_in & ~cs_n_in & port_en; // RQ2 RQ3
	assign pins_raw = '{cs_n: cs_n_in, rd_n: rd_n_in,
		cnv_n: convert_start_n_in, pd: power_down_in};

	asr_sync2 #(
		.W(PIN_W),
		.RST_VAL(PINS_RST)
	) u_pin_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// ----------------------------------------------------------------
	// conversion timer
	// ----------------------------------------------------------------

	asr_conv_e state_reg;
	asr_conv_e state_next;
	logic [7:0] conv_cnt_reg;
	logic [7:0] conv_cnt_next;
	logic cnv_prev_reg;
	logic cnv_fall;
	logic start_ok;
	logic [DATA_W-1:0] result_reg;
	logic busy_prev_reg;
	logic busy_fall;

	assign cnv_fall = cnv_prev_reg & ~pins_s.cnv_n;
	// a start request counts only while idle and powered up
	assign start_ok = (state_reg == ASR_IDLE) & cnv_fall & ~pins_s.pd; // RQ17
	assign busy_out = (state_reg != ASR_IDLE);
	assign busy_fall = busy_prev_reg & ~busy_out;
	assign conv_start_out = start_ok;

	// next state; conv and store ignore new requests and power down
	always_comb
	begin
		state_next = state_reg;
		conv_cnt_next = conv_cnt_reg;
		case (state_reg)
			ASR_IDLE:
			begin
				conv_cnt_next = CONV_CNT_RST;
				if (start_ok)
					state_next = ASR_CONV;
			end
			ASR_CONV:
			begin
				conv_cnt_next = conv_cnt_reg + 8'h01;
				if (conv_cnt_reg == CONV_LAST) // RQ17
					state_next = ASR_STORE;
			end
			ASR_STORE:
				state_next = ASR_IDLE;
			default:
				state_next = ASR_IDLE;
		endcase
	end

	// state, counter and edge history
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= ASR_IDLE;
			conv_cnt_reg <= CONV_CNT_RST;
			cnv_prev_reg <= 1'b1;
			busy_prev_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			conv_cnt_reg <= conv_cnt_next;
			cnv_prev_reg <= pins_s.cnv_n;
			busy_prev_reg <= busy_out;
		end
	end

	// result latched as busy falls; earlier value kept until then
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			result_reg <= RESULT_RST;
		else if (state_reg == ASR_STORE)
			result_reg <= conv_result_in; // RQ5
	end

	// ----------------------------------------------------------------
	// read frame capture and overrun detection
	// ----------------------------------------------------------------

	logic cs_prev_reg;
	logic frame_start;
	logic frame_active;
	logic [DATA_W-1:0] snap_reg;
	logic chain_en_reg;
	logic overrun_reg;
	logic overrun_next;

	assign frame_start = cs_prev_reg & ~pins_s.cs_n & port_en;
	assign frame_active = ~pins_s.cs_n & ~pins_s.rd_n & port_en;
	// a read still short of its last bit when busy falls is too late
	assign overrun_next = busy_fall & frame_active & ~done_s; // RQ11
	assign read_overrun_flag_out = overrun_reg;

	// word snapshot; stable for the whole frame, read by the link side
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cs_prev_reg <= 1'b1;
			snap_reg <= RESULT_RST;
			chain_en_reg <= 1'b0;
		end
		else
		begin
			cs_prev_reg <= pins_s.cs_n;
			if (frame_start)
			begin
				snap_reg <= result_reg; // RQ10 RQ14
				chain_en_reg <= ~busy_out; // RQ8
			end
		end
	end

	// one-cycle overrun pulse
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			overrun_reg <= 1'b0;
		else
			overrun_reg <= overrun_next;
	end

	// ----------------------------------------------------------------
	// link side: shift register on the host clock
	// ----------------------------------------------------------------

	logic [CNT_W-1:0] bit_cnt_reg;
	logic [DATA_W-1:0] shift_reg;
	logic chain_bit_reg;
	logic chain_bit;
	logic done_reg;
	logic out_bit;

	// chain data only in read-after-conversion frames
	assign chain_bit = chain_en_reg & chain_bit_reg; // RQ8 RQ12

	// chain input taken on the rising edge, opposite the shift
	always_ff @(posedge sclk_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			chain_bit_reg <= 1'b0;
		else
			chain_bit_reg <= chain_data_in; // RQ9
	end

	// falling edge advances; old bit holds through each edge
	always_ff @(negedge sclk_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			bit_cnt_reg <= '0;
			shift_reg <= RESULT_RST;
		end
		else
		begin
			if (bit_cnt_reg != BITS_PER_WORD)
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			if (bit_cnt_reg == '0)
				shift_reg <= {snap_reg[DATA_W-2:0], chain_bit}; // RQ20
			else
				shift_reg <= {shift_reg[DATA_W-2:0], chain_bit}; // RQ5 RQ6 RQ7
		end
	end

	// end of own word, crossed back to the system clock
	always_ff @(negedge sclk_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			done_reg <= 1'b0;
		else if (bit_cnt_reg == LAST_OWN_BIT)
			done_reg <= 1'b1;
	end

	asr_sync2 #(
		.W(1),
		.RST_VAL(1'b0)
	) u_done_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(done_reg),
		.sync_out(done_s)
	);

	// ----------------------------------------------------------------
	// serial output pin
	// ----------------------------------------------------------------

	// MSB straight from the snapshot until the first falling edge
	assign out_bit = (bit_cnt_reg == '0) ? snap_reg[DATA_W-1] :
		shift_reg[DATA_W-1]; // RQ20
	assign serial_data_out = out_bit;
	// driven only with chip select and read both low
	assign serial_data_oe_out = ~cs_n_in & ~rd_n_in & port_en; // RQ2 RQ19

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	sequence s_conv_run;
		busy_out throughout (##[1:CONV_WAIT] (state_reg == ASR_STORE));
	endsequence

	sequence s_store_then_idle;
		(state_reg == ASR_STORE) ##1 (state_reg == ASR_IDLE);
	endsequence

	a_conv_no_abort: assert property ( // RQ17
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(busy_out) |-> s_conv_run)
		else $error("conversion did not run to its end");

	a_conv_full_len: assert property ( // RQ17
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(busy_out) |-> ##CONV_CYCLES s_store_then_idle)
		else $error("conversion length wrong");

	a_start_idle: assert property ( // RQ17
		@(posedge clk_in) disable iff (!rst_n_in)
		conv_start_out |-> !busy_out ##1 busy_out)
		else $error("start pulse outside idle");

	a_overrun_cause: assert property ( // RQ11
		@(posedge clk_in) disable iff (!rst_n_in)
		read_overrun_flag_out |-> $past(busy_fall) && !busy_out
			##1 !read_overrun_flag_out)
		else $error("overrun pulse without late read");

	a_snap_source: assert property ( // RQ10
		@(posedge clk_in) disable iff (!rst_n_in)
		frame_start |=> snap_reg == $past(result_reg)
			&& chain_en_reg == !$past(busy_out))
		else $error("snapshot did not take stored result");

	a_oe_gate: assert property ( // RQ19
		@(posedge clk_in) disable iff (!rst_n_in)
		serial_data_oe_out |-> !cs_n_in && !rd_n_in
			&& clock_source_select_in && interface_select_in)
		else $error("output driven while deselected");

	a_msb_second: assert property ( // RQ5
		@(negedge sclk_in) disable iff (!frame_rst_n)
		bit_cnt_reg == '0 |=> serial_data_out == snap_reg[DATA_W-2])
		else $error("second bit wrong after first edge");

	a_chain_follow: assert property ( // RQ9
		@(negedge sclk_in) disable iff (!frame_rst_n)
		bit_cnt_reg == LAST_OWN_BIT ##1 bit_cnt_reg == BITS_PER_WORD
			|-> serial_data_out == $past(chain_bit, DATA_W))
		else $error("chain bit did not follow own word");

	a_no_chain_during: assert property ( // RQ8
		@(negedge sclk_in) disable iff (!frame_rst_n)
		!chain_en_reg && bit_cnt_reg == BITS_PER_WORD
			|-> !serial_data_out)
		else $error("chain data passed in during-read frame");

	a_cnt_bound: assert property ( // RQ5
		@(negedge sclk_in) disable iff (!frame_rst_n)
		bit_cnt_reg <= BITS_PER_WORD
			&& (done_reg == (bit_cnt_reg == BITS_PER_WORD)))
		else $error("bit counter out of step");

endmodule // asr_serial_port

// ==== bench/asr_host.sv ====
// host side model: gated shift clock, frame control and chain data
`timescale 1ns/100ps

module asr_host
(
	// pins toward the device
	output logic sclk_out,
	output logic cs_n_out,
	output logic rd_n_out,
	output logic chain_out,
	// serial data from the device
	input wire logic sdo_in
);
	logic [31:0] got;
	logic [15:0] ch;

	// idle pins, clock stands still outside frames
	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		chain_out = 1'b0;
		got = '0;
		ch = '0;
	end

	// one frame; idle-low samples on rising, idle-high before falling
	task automatic frame(input int nbits, input logic [15:0] chain,
		input bit hold, input bit idle_hi);
		int i;
		ch = chain;
		sclk_out = idle_hi;
		#10;
		chain_out = ch[15];
		cs_n_out = 1'b0;
		rd_n_out = 1'b0;
		#60;
		for (i = 0; i < nbits; i++)
		begin
			if (idle_hi)
			begin
				#24 got = {got[30:0], sdo_in};
				sclk_out = 1'b0;
				#24 sclk_out = 1'b1;
			end
			else
			begin
				#24 sclk_out = 1'b1;
				got = {got[30:0], sdo_in};
				#24 sclk_out = 1'b0;
			end
			// upstream converter shifts on the edge just driven: falling when idle-low, rising when idle-high
			ch = {ch[14:0], 1'b0};
			chain_out = ch[15];
		end
		#24;
		if (!hold)
			release_frame();
	endtask

	// end a frame and keep the gap before the next one
	task automatic release_frame();
		cs_n_out = 1'b1;
		rd_n_out = 1'b1;
		#60;
	endtask
endmodule // asr_host

// ==== bench/asr_serial_port_tb.sv ====
// self-checking bench for the slave serial readout port
`timescale 1ns/100ps

module asr_serial_port_tb;
	import asr_pkg::*;
	logic clk_in, rst_n_in, convert_start_n_in, power_down_in;
	logic [DATA_W-1:0] conv_result_in;
	logic [15:0] chain, prev;
	logic src_sel, if_sel;
	wire logic sclk, cs_n, rd_n, chain_d, sdo, sdo_oe, busy, ovr;
	wire logic sdo_pin;
	int fail_count, compares, seed, ovr_seen, k;
	logic [15:0] res_q[$];

	// ----------------------------------------------------------------
	// clock, host model and design
	// ----------------------------------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	asr_host host (.sclk_out(sclk), .cs_n_out(cs_n), .rd_n_out(rd_n),
		.chain_out(chain_d), .sdo_in(sdo_pin));

	// a released pin shows the inverse of the current sdo value
	assign sdo_pin = sdo_oe ? sdo : ~sdo;

	asr_serial_port dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .rd_n_in(rd_n),
		.convert_start_n_in(convert_start_n_in),
		.power_down_in(power_down_in), .clock_source_select_in(src_sel),
		.interface_select_in(if_sel), .chain_data_in(chain_d),
		.serial_data_out(sdo), .serial_data_oe_out(sdo_oe),
		.conv_result_in(conv_result_in), .conv_start_out(),
		.busy_out(busy), .read_overrun_flag_out(ovr));

	// count overrun pulses
	always @(posedge clk_in)
		if (ovr === 1'b1)
			ovr_seen++;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("fail_count=%0d compares=%0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// request a conversion and wait for busy
	task automatic start_conv();
		int n;
		@(posedge clk_in);
		#1 convert_start_n_in = 1'b0;
		for (n = 0; n < 10 && busy !== 1'b1; n++)
			@(posedge clk_in) #1;
		if (busy !== 1'b1)
		begin
			fail_count++;
			final_report();
		end
		convert_start_n_in = 1'b1;
	endtask

	// wait for the end of conversion, poking it with requests
	task automatic finish(input bit timed);
		int n;
		for (n = 0; busy === 1'b1 && n < 400; n++)
		begin
			@(posedge clk_in) #1;
			if (n == 19)
				{convert_start_n_in, power_down_in} = 2'b01;
			if (n == 39)
				{convert_start_n_in, power_down_in} = 2'b10;
		end
		if (busy !== 1'b0)
		begin
			fail_count++;
			final_report();
		end
		if (timed)
			check(32'(n), 32'(CONV_CYCLES + 1));
		res_q.push_back(conv_result_in);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{fail_count, compares, ovr_seen} = '0;
		seed = 69439;
		rst_n_in = 1'b0;
		convert_start_n_in = 1'b1;
		power_down_in = 1'b0;
		{src_sel, if_sel} = 2'b11;
		conv_result_in = '0;
		res_q.push_back(RESULT_RST);
		repeat (8) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 check({busy, sdo_oe}, 32'h0);
		for (k = 0; k < 3; k++)
		begin
			conv_result_in = 16'($random(seed));
			chain = 16'($random(seed));
			start_conv();
			finish(1'b1);
			host.frame(18, chain, 1'b0, 1'b0);
			check(host.got[17:0], {res_q[$], chain[15:14]});
			prev = res_q[$];
			conv_result_in = 16'($random(seed));
			start_conv();
			host.frame(17, 16'h0000, 1'b0, 1'b0);
			check(host.got[16:0], {prev, 1'b0});
			finish(1'b0);
			repeat (4) @(posedge clk_in);
			check(32'(ovr_seen), 32'h0);
		end
		// read begun after a conversion runs on into the next one
		conv_result_in = 16'($random(seed));
		chain = 16'($random(seed));
		fork
			host.frame(18, chain, 1'b0, 1'b0);
			begin
				repeat (20) @(posedge clk_in);
				start_conv();
			end
		join
		check(host.got[17:0], {res_q[$], chain[15:14]});
		finish(1'b0);
		// idle-high clock, own word taken before each falling edge
		host.frame(16, 16'h0000, 1'b0, 1'b1);
		check(host.got[15:0], res_q[$]);
		repeat (4) @(posedge clk_in);
		check(32'(ovr_seen), 32'h0);
		// read still short of its last bit when busy falls
		conv_result_in = 16'($random(seed));
		start_conv();
		host.frame(4, 16'h0000, 1'b1, 1'b0);
		check(sdo_oe, 1'b1);
		finish(1'b0);
		repeat (4) @(posedge clk_in);
		check(32'(ovr_seen), 32'h1);
		// port drives only with both selects high
		#1 if_sel = 1'b0;
		@(posedge clk_in) #1 check(sdo_oe, 1'b0);
		{if_sel, src_sel} = 2'b10;
		@(posedge clk_in) #1 check(sdo_oe, 1'b0);
		src_sel = 1'b1;
		@(posedge clk_in) #1 check(sdo_oe, 1'b1);
		host.release_frame();
		check(sdo_oe, 1'b0);
		final_report();
	end
endmodule // asr_serial_port_tb
